// ===== hdl/ico_pkg.sv
// What this block does
// R1 - Two scratch bytes, no hardware effect
// R2 - Pattern location from high bits and low
// R3 - Location picks 2KB block in 4MB
// R4 - Icon lower 1KB, cursor upper 1KB
// R5 - Cursor enable bit 7, resets off
// R6 - Icon enable bit 7, control resets zero
// R7 - Icon double-size select in bit 6
// R8 - Three icon colour bytes
// R9 - Icon X start eleven bits
// R10 - Icon Y start eleven bits
// R11 - Cursor X eleven bits, reset zero
// R12 - X select clear: full X position
// R13 - X select set: low five clipped
// R14 - Cursor Y eleven bits, reset zero
// R15 - Y select clear: full Y position
// R16 - Y select set: low five clipped
// R17 - Cursor colours expanded to 24 bits
// R18 - Fore and back colour bytes, reset zero
// R19 - Expand components by bit repetition
// R20 - Reserved bits read zero, ignore writes
`default_nettype none
package ico_pkg;
  localparam logic [7:0] IDX_SCRATCH_THREE  = 8'h74;
  localparam logic [7:0] IDX_SCRATCH_FOUR   = 8'h75;
  localparam logic [7:0] IDX_PAT_LOW        = 8'h80;
  localparam logic [7:0] IDX_CUR_EN_PAT_HI  = 8'h81;
  localparam logic [7:0] IDX_ICON_CONTROL   = 8'h82;
  localparam logic [7:0] IDX_ICON_RESERVED  = 8'h83;
  localparam logic [7:0] IDX_ICON_COLOUR_1  = 8'h84;
  localparam logic [7:0] IDX_ICON_COLOUR_2  = 8'h85;
  localparam logic [7:0] IDX_ICON_COLOUR_3  = 8'h86;
  localparam logic [7:0] IDX_CUR_X_LOW      = 8'h88;
  localparam logic [7:0] IDX_CUR_X_HIGH     = 8'h89;
  localparam logic [7:0] IDX_CUR_Y_LOW      = 8'h8a;
  localparam logic [7:0] IDX_CUR_Y_HIGH     = 8'h8b;
  localparam logic [7:0] IDX_CUR_FORE       = 8'h8c;
  localparam logic [7:0] IDX_CUR_BACK       = 8'h8d;
  localparam logic [7:0] IDX_ICON_X_LOW     = 8'h90;
  localparam logic [7:0] IDX_ICON_X_HIGH    = 8'h91;
  localparam logic [7:0] IDX_ICON_Y_LOW     = 8'h92;
  localparam logic [7:0] IDX_ICON_Y_HIGH    = 8'h93;
  localparam int        ON_BIT             = 7;
  localparam int        DOUBLE_BIT         = 6;
  localparam int        EDGE_BIT           = 3;
  localparam logic [7:0] HIGH3_MASK         = 8'h07;
  localparam logic [7:0] CUR_HIGH_MASK      = 8'h0f;
  localparam logic [7:0] CUR_EN_HIGH_MASK   = 8'h87;
  localparam logic [7:0] ICON_CTRL_MASK     = 8'hc0;
  localparam logic [7:0] RESET_ZERO         = 8'h00;
  localparam int        BLOCK_ADDR_BITS    = 11;
  localparam int        BLOCK_OFFSET_BITS  = 11;
  localparam int        MEM_ADDR_BITS      = 22;
  localparam int        HALF_OFFSET_BITS   = 10;
  localparam int        CLIP_BITS          = 5;
  localparam logic [5:0] ICON_SIZE_NORMAL  = 6'h3f;
endpackage : ico_pkg
`default_nettype wire

// ===== hdl/ico_colour_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ico_colour_if;
  logic [7:0]  packed_332;
  logic [23:0] rgb_888;
  modport src (output packed_332, input rgb_888);
  modport exp (input packed_332, output rgb_888);
endinterface : ico_colour_if
`default_nettype wire

// ===== hdl/ico_colour_expand.sv
`timescale 1ns/100ps
`default_nettype none
// Purely combinational; the top registers the result
module ico_colour_expand (
  ico_colour_if.exp col
);
  logic [2:0] red;
  logic [2:0] grn;
  logic [1:0] blu;
  assign red = col.packed_332[7:5];
  assign grn = col.packed_332[4:2];
  assign blu = col.packed_332[1:0];
  assign col.rgb_888 = {red, red, red[2:1],
                        grn, grn, grn[2:1],
                        blu, blu, blu, blu}; // R17 R19
endmodule // ico_colour_expand
`default_nettype wire

// ===== hdl/ico_overlay_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Indexed register bank for the icon and cursor overlays.
// A write with wr_en_in stores data_in at index_in; read_data_out
// shows the addressed register one clock after the index is given.
module ico_overlay_regs (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  index_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  read_data_out,
  output logic      [21:0] icon_base_out,
  output logic      [21:0] cursor_base_out,
  output logic             cursor_on_out,
  output logic             icon_on_out,
  output logic             icon_double_out,
  output logic      [6:0]  icon_size_out,
  output logic      [23:0] icon_colours_out,
  output logic      [10:0] icon_x_out,
  output logic      [10:0] icon_y_out,
  output logic      [10:0] cursor_x_out,
  output logic      [10:0] cursor_y_out,
  output logic             cursor_x_clip_out,
  output logic             cursor_y_clip_out,
  output logic      [4:0]  cursor_x_skip_out,
  output logic      [4:0]  cursor_y_skip_out,
  output logic      [23:0] cursor_fore_rgb_out,
  output logic      [23:0] cursor_back_rgb_out
);

  logic [7:0] scratch_three_r;
  logic [7:0] scratch_four_r;
  logic [7:0] pattern_location_low_r;
  logic [2:0] pattern_high_r;
  logic       cursor_on_bit_r;
  logic       icon_on_bit_r;
  logic       icon_double_bit_r;
  logic [7:0] icon_colour_r [3];
  logic [7:0] icon_x_low_r;
  logic [2:0] icon_x_high_r;
  logic [7:0] icon_y_low_r;
  logic [2:0] icon_y_high_r;
  logic [7:0] cursor_x_low_r;
  logic [2:0] cursor_x_upper_bits_r;
  logic       cursor_x_edge_select_r;
  logic [7:0] cursor_y_low_r;
  logic [2:0] cursor_y_upper_bits_r;
  logic       cursor_y_edge_select_r;
  logic [7:0] cursor_fore_colour_r;
  logic [7:0] cursor_back_colour_r;
  logic [7:0] read_nxt;
  logic [10:0] pattern_loc;

  function automatic logic hit(input logic [7:0] idx,
                               input logic [7:0] want);
    hit = (idx == want);
  endfunction

  function automatic logic wr_hit(input logic       we,
                                  input logic [7:0] idx,
                                  input logic [7:0] want);
    wr_hit = we && hit(idx, want);
  endfunction

  // Every 11-bit field is a three-bit high part over a full low byte
  function automatic logic [10:0] join11(input logic [2:0] hi,
                                         input logic [7:0] lo);
    join11 = {hi, lo};
  endfunction

  // A clipped axis has no position, only a count of hidden pixels
  function automatic logic [10:0] axis_pos(input logic       clip,
                                           input logic [2:0] hi,
                                           input logic [7:0] lo);
    axis_pos = clip ? 11'h000 : join11(hi, lo);
  endfunction

  function automatic logic [4:0] axis_skip(input logic       clip,
                                           input logic [7:0] lo);
    axis_skip = clip ? lo[4:0] : 5'h00;
  endfunction

  // Scratch bytes are never reset: contents undefined at power-on
  always_ff @(posedge clk_in) begin
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_SCRATCH_THREE)) begin
      scratch_three_r <= data_in; // R1
    end
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_SCRATCH_FOUR)) begin
      scratch_four_r <= data_in; // R1
    end
  end

  // Pattern location and icon data, undefined after power-on
  always_ff @(posedge clk_in) begin
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_PAT_LOW)) begin
      pattern_location_low_r <= data_in; // R2
    end
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_EN_PAT_HI)) begin
      pattern_high_r <= data_in[2:0]; // R2
    end
  end

  // Icon start, like the pattern, is undefined until written
  always_ff @(posedge clk_in) begin
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_ICON_X_LOW)) begin
      icon_x_low_r <= data_in; // R9
    end
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_ICON_X_HIGH)) begin
      icon_x_high_r <= data_in[2:0]; // R9
    end
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_ICON_Y_LOW)) begin
      icon_y_low_r <= data_in; // R10
    end
    if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_ICON_Y_HIGH)) begin
      icon_y_high_r <= data_in[2:0]; // R10
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_icon_col
      always_ff @(posedge clk_in) begin
        if (wr_hit(wr_en_in, index_in,
                   8'(ico_pkg::IDX_ICON_COLOUR_1 + 8'(gi)))) begin
          icon_colour_r[gi] <= data_in; // R8
        end
      end
    end
  endgenerate

  // Enables clear at reset so nothing is drawn from garbage state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_on_bit_r <= 1'b0; // R5
    end else begin
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_EN_PAT_HI)) begin
        cursor_on_bit_r <= data_in[ico_pkg::ON_BIT]; // R5
      end
    end
  end

  // Zoom clears with the enable so a fresh icon shows at normal size
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      icon_on_bit_r     <= 1'b0; // R6
      icon_double_bit_r <= 1'b0; // R6
    end else begin
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_ICON_CONTROL)) begin
        icon_on_bit_r     <= data_in[ico_pkg::ON_BIT]; // R6
        icon_double_bit_r <= data_in[ico_pkg::DOUBLE_BIT]; // R7
      end
    end
  end

  // Cursor starts unclipped at the top left corner
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_x_low_r         <= ico_pkg::RESET_ZERO; // R11
      cursor_x_upper_bits_r  <= 3'h0; // R11
      cursor_x_edge_select_r <= 1'b0; // R12
    end else begin
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_X_LOW)) begin
        cursor_x_low_r <= data_in; // R11
      end
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_X_HIGH)) begin
        cursor_x_upper_bits_r  <= data_in[2:0]; // R11
        cursor_x_edge_select_r <= data_in[ico_pkg::EDGE_BIT]; // R12 R13
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_y_low_r         <= ico_pkg::RESET_ZERO; // R14
      cursor_y_upper_bits_r  <= 3'h0; // R14
      cursor_y_edge_select_r <= 1'b0; // R15
    end else begin
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_Y_LOW)) begin
        cursor_y_low_r <= data_in; // R14
      end
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_Y_HIGH)) begin
        cursor_y_upper_bits_r  <= data_in[2:0]; // R14
        cursor_y_edge_select_r <= data_in[ico_pkg::EDGE_BIT]; // R15 R16
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_fore_colour_r <= ico_pkg::RESET_ZERO; // R18
      cursor_back_colour_r <= ico_pkg::RESET_ZERO; // R18
    end else begin
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_FORE)) begin
        cursor_fore_colour_r <= data_in; // R18
      end
      if (wr_hit(wr_en_in, index_in, ico_pkg::IDX_CUR_BACK)) begin
        cursor_back_colour_r <= data_in; // R18
      end
    end
  end

  // Read mux; reserved bits and index 83h return zero
  always_comb begin
    read_nxt = ico_pkg::RESET_ZERO;
    case (index_in)
      ico_pkg::IDX_SCRATCH_THREE: read_nxt = scratch_three_r;
      ico_pkg::IDX_SCRATCH_FOUR:  read_nxt = scratch_four_r;
      ico_pkg::IDX_PAT_LOW:       read_nxt = pattern_location_low_r;
      ico_pkg::IDX_CUR_EN_PAT_HI:
        read_nxt = {cursor_on_bit_r, 4'h0, pattern_high_r}; // R20
      ico_pkg::IDX_ICON_CONTROL:
        read_nxt = {icon_on_bit_r, icon_double_bit_r, 6'h00}; // R20
      ico_pkg::IDX_ICON_COLOUR_1: read_nxt = icon_colour_r[0];
      ico_pkg::IDX_ICON_COLOUR_2: read_nxt = icon_colour_r[1];
      ico_pkg::IDX_ICON_COLOUR_3: read_nxt = icon_colour_r[2];
      ico_pkg::IDX_CUR_X_LOW:     read_nxt = cursor_x_low_r;
      ico_pkg::IDX_CUR_X_HIGH:
        read_nxt = {4'h0, cursor_x_edge_select_r,
                    cursor_x_upper_bits_r}; // R20
      ico_pkg::IDX_CUR_Y_LOW:     read_nxt = cursor_y_low_r;
      ico_pkg::IDX_CUR_Y_HIGH:
        read_nxt = {4'h0, cursor_y_edge_select_r,
                    cursor_y_upper_bits_r}; // R20
      ico_pkg::IDX_CUR_FORE:      read_nxt = cursor_fore_colour_r;
      ico_pkg::IDX_CUR_BACK:      read_nxt = cursor_back_colour_r;
      ico_pkg::IDX_ICON_X_LOW:    read_nxt = icon_x_low_r;
      ico_pkg::IDX_ICON_X_HIGH:   read_nxt = {5'h00, icon_x_high_r};
      ico_pkg::IDX_ICON_Y_LOW:    read_nxt = icon_y_low_r;
      ico_pkg::IDX_ICON_Y_HIGH:   read_nxt = {5'h00, icon_y_high_r};
      default:                    read_nxt = ico_pkg::RESET_ZERO; // R20
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      read_data_out <= ico_pkg::RESET_ZERO;
    end else begin
      read_data_out <= read_nxt;
    end
  end

  // Block base = location * 2KB; icon lower half, cursor upper half
  assign pattern_loc = {pattern_high_r, pattern_location_low_r}; // R2

  ico_colour_if fore_if ();
  ico_colour_if back_if ();
  assign fore_if.packed_332 = cursor_fore_colour_r;
  assign back_if.packed_332 = cursor_back_colour_r;
  ico_colour_expand u_fore_expand (.col(fore_if.exp));
  ico_colour_expand u_back_expand (.col(back_if.exp));

  // Register outputs so the pixel pipeline sees clean flops
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      icon_base_out   <= 22'h00_0000;
      cursor_base_out <= 22'h00_0000;
    end else begin
      icon_base_out   <= {pattern_loc, 1'b0,
                          10'h000}; // R3 R4
      cursor_base_out <= {pattern_loc, 1'b1,
                          10'h000}; // R3 R4
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_on_out   <= 1'b0;
      icon_on_out     <= 1'b0;
      icon_double_out <= 1'b0;
      icon_size_out   <= 7'h00;
    end else begin
      cursor_on_out   <= cursor_on_bit_r; // R5
      icon_on_out     <= icon_on_bit_r; // R6
      icon_double_out <= icon_double_bit_r; // R7
      // Displayed edge minus one: 63 normal, 127 zoomed
      icon_size_out   <= icon_double_bit_r
                         ? {ico_pkg::ICON_SIZE_NORMAL, 1'b1}
                         : {1'b0, ico_pkg::ICON_SIZE_NORMAL}; // R7
    end
  end

  // Until written, icon colours and start carry unknowns out
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      icon_colours_out <= 24'h00_0000;
      icon_x_out       <= 11'h000;
      icon_y_out       <= 11'h000;
    end else begin
      icon_colours_out <= {icon_colour_r[2], icon_colour_r[1],
                           icon_colour_r[0]}; // R8
      icon_x_out       <= join11(icon_x_high_r, icon_x_low_r); // R9
      icon_y_out       <= join11(icon_y_high_r, icon_y_low_r); // R10
    end
  end

  // Clipped cursor sits at the edge; only the skip count matters
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_x_out      <= 11'h000;
      cursor_x_clip_out <= 1'b0;
      cursor_x_skip_out <= 5'h00;
    end else begin
      cursor_x_out      <= axis_pos(cursor_x_edge_select_r,
                                    cursor_x_upper_bits_r,
                                    cursor_x_low_r); // R12
      cursor_x_clip_out <= cursor_x_edge_select_r; // R13
      cursor_x_skip_out <= axis_skip(cursor_x_edge_select_r,
                                     cursor_x_low_r); // R13
    end
  end

  // Same scheme on the vertical axis, clipped at the top
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_y_out      <= 11'h000;
      cursor_y_clip_out <= 1'b0;
      cursor_y_skip_out <= 5'h00;
    end else begin
      cursor_y_out      <= axis_pos(cursor_y_edge_select_r,
                                    cursor_y_upper_bits_r,
                                    cursor_y_low_r); // R15
      cursor_y_clip_out <= cursor_y_edge_select_r; // R16
      cursor_y_skip_out <= axis_skip(cursor_y_edge_select_r,
                                     cursor_y_low_r); // R16
    end
  end

  // Expansion is combinational; this flop keeps the outputs clean
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cursor_fore_rgb_out <= 24'h00_0000;
      cursor_back_rgb_out <= 24'h00_0000;
    end else begin
      cursor_fore_rgb_out <= fore_if.rgb_888; // R17
      cursor_back_rgb_out <= back_if.rgb_888; // R17
    end
  end

endmodule // ico_overlay_regs
`default_nettype wire

// ===== dv/ico_overlay_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ico_overlay_regs_monitor (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [7:0]  index_in,
  input wire logic        wr_en_in,
  input wire logic [7:0]  data_in,
  input wire logic [7:0]  read_data_out,
  input wire logic        icon_double_out,
  input wire logic [6:0]  icon_size_out,
  input wire logic        cursor_on_out,
  input wire logic [10:0] cursor_x_out,
  input wire logic [10:0] cursor_y_out,
  input wire logic        cursor_x_clip_out,
  input wire logic        cursor_y_clip_out,
  input wire logic [4:0]  cursor_x_skip_out,
  input wire logic [4:0]  cursor_y_skip_out,
  input wire logic [23:0] cursor_fore_rgb_out,
  input wire logic [23:0] cursor_back_rgb_out
);
  function automatic logic [23:0] ex(input logic [7:0] d);
    return {d[7:5], d[7:5], d[7:6], d[4:2], d[4:2], d[4:3], {4{d[1:0]}}};
  endfunction
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Second write to the same index masks the first, so require a gap
  property lat(idx, got, want);
    (wr_en_in && index_in == idx) ##1 !(wr_en_in && index_in == idx)
      |-> ##2 got == want;
  endproperty
  x_clip_zero_a: assert property (
    cursor_x_clip_out |-> cursor_x_out == 11'h000)
    else $error("clipped cursor x not zero");
  x_skip_zero_a: assert property (
    !cursor_x_clip_out |-> cursor_x_skip_out == 5'h00)
    else $error("unclipped cursor x skip not zero");
  y_clip_zero_a: assert property (
    cursor_y_clip_out |-> cursor_y_out == 11'h000)
    else $error("clipped cursor y not zero");
  y_skip_zero_a: assert property (
    !cursor_y_clip_out |-> cursor_y_skip_out == 5'h00)
    else $error("unclipped cursor y skip not zero");
  icon_size_a: assert property ($past(rstn_in) |->
    icon_size_out == (icon_double_out ? 7'h7f : 7'h3f))
    else $error("icon size does not follow zoom");
  rsvd_read_a: assert property (
    $past(index_in) == 8'h83 |-> read_data_out == 8'h00)
    else $error("reserved index read not zero");
  fore_expand_a: assert property (
    lat(8'h8c, cursor_fore_rgb_out, ex($past(data_in, 3))))
    else $error("foreground expansion wrong");
  back_expand_a: assert property (
    lat(8'h8d, cursor_back_rgb_out, ex($past(data_in, 3))))
    else $error("background expansion wrong");
  x_edge_sel_a: assert property (
    lat(8'h89, cursor_x_clip_out, $past(data_in[3], 3)))
    else $error("x edge select not applied");
  cursor_on_a: assert property (
    lat(8'h81, cursor_on_out, $past(data_in[7], 3)))
    else $error("cursor enable not applied");
  cover property (cursor_x_clip_out && cursor_y_clip_out);
  cover property (icon_double_out);
  cover property (wr_en_in && index_in == 8'h83);
endmodule // ico_overlay_regs_monitor
bind ico_overlay_regs ico_overlay_regs_monitor i_ico_overlay_regs_monitor (
  .clk_in(clk_in), .rstn_in(rstn_in), .index_in(index_in),
  .wr_en_in(wr_en_in), .data_in(data_in), .read_data_out(read_data_out),
  .icon_double_out(icon_double_out), .icon_size_out(icon_size_out),
  .cursor_on_out(cursor_on_out), .cursor_x_out(cursor_x_out),
  .cursor_y_out(cursor_y_out), .cursor_x_clip_out(cursor_x_clip_out),
  .cursor_y_clip_out(cursor_y_clip_out),
  .cursor_x_skip_out(cursor_x_skip_out),
  .cursor_y_skip_out(cursor_y_skip_out),
  .cursor_fore_rgb_out(cursor_fore_rgb_out),
  .cursor_back_rgb_out(cursor_back_rgb_out));
`default_nettype wire

// ===== dv/ico_overlay_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ico_overlay_regs_tb;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [7:0]  index_in = 8'h00;
  logic        wr_en_in = 1'b0;
  logic [7:0]  data_in = 8'h00;
  logic [7:0]  read_data_out;
  logic [21:0] icon_base_out, cursor_base_out;
  logic        cursor_on_out, icon_on_out, icon_double_out;
  logic [6:0]  icon_size_out;
  logic [23:0] icon_colours_out, fore_q, back_q;
  logic [10:0] icon_x_out, icon_y_out, cursor_x_out, cursor_y_out;
  logic        x_clip, y_clip;
  logic [4:0]  x_skip, y_skip;
  int          fails = 0;
  int          n_compared = 0;
  ico_overlay_regs i_ico_overlay_regs (
    .clk_in(clk_in), .rstn_in(rstn_in), .index_in(index_in),
    .wr_en_in(wr_en_in), .data_in(data_in), .read_data_out(read_data_out),
    .icon_base_out(icon_base_out), .cursor_base_out(cursor_base_out),
    .cursor_on_out(cursor_on_out), .icon_on_out(icon_on_out),
    .icon_double_out(icon_double_out), .icon_size_out(icon_size_out),
    .icon_colours_out(icon_colours_out), .icon_x_out(icon_x_out),
    .icon_y_out(icon_y_out), .cursor_x_out(cursor_x_out),
    .cursor_y_out(cursor_y_out), .cursor_x_clip_out(x_clip),
    .cursor_y_clip_out(y_clip), .cursor_x_skip_out(x_skip),
    .cursor_y_skip_out(y_skip), .cursor_fore_rgb_out(fore_q),
    .cursor_back_rgb_out(back_q));
  initial forever #25 clk_in = ~clk_in;
  function automatic logic [23:0] ex(input logic [7:0] d);
    return {d[7:5], d[7:5], d[7:6], d[4:2], d[4:2], d[4:3], {4{d[1:0]}}};
  endfunction
  task automatic end_of_test;
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // Strobe stays high across consecutive writes, dropped by rd or idle
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    index_in = idx;
    data_in = d;
    wr_en_in = 1'b1;
    @(negedge clk_in);
  endtask
  task automatic idle;
    wr_en_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] want);
    wr_en_in = 1'b0;
    index_in = idx;
    @(negedge clk_in);
    chk(read_data_out, want);
  endtask
  task automatic t_reset;
    wr_en_in = 1'b0;
    rstn_in = 1'b0;
    repeat (4) @(negedge clk_in);
    rstn_in = 1'b1;
    chk({cursor_on_out, icon_on_out}, 0);
    chk(fore_q | back_q, 0);
    chk({cursor_x_out, cursor_y_out}, 0);
    rd(8'h82, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h8a, 8'h00);
    rd(8'h8b, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h8d, 8'h00);
  endtask
  task automatic t_scratch;
    wr(8'h74, 8'ha5);
    wr(8'h75, 8'h5a);
    wr(8'h84, 8'h11);
    wr(8'h85, 8'h22);
    wr(8'h86, 8'h33);
    idle();
    rd(8'h74, 8'ha5);
    rd(8'h75, 8'h5a);
    rd(8'h85, 8'h22);
    chk(icon_colours_out, 24'h33_2211);
  endtask
  task automatic t_reserved;
    logic [7:0] ix [8] = '{8'h83, 8'h81, 8'h82, 8'h89, 8'h8b, 8'h91, 8'h93,
                           8'h87};
    logic [7:0] mk [8] = '{8'h00, 8'h87, 8'hc0, 8'h0f, 8'h0f, 8'h07, 8'h07,
                           8'h00};
    for (int i = 0; i < 8; i++) begin
      wr(ix[i], 8'hff);
      rd(ix[i], mk[i]);
    end
  endtask
  task automatic t_pattern;
    wr(8'h80, 8'h34);
    wr(8'h81, 8'h85);
    idle();
    chk(icon_base_out, {11'h534, 11'h000});
    chk(cursor_base_out, {11'h534, 1'b1, 10'h000});
    chk(cursor_on_out, 1);
    wr(8'h81, 8'h05);
    idle();
    chk(cursor_on_out, 0);
    rd(8'h81, 8'h05);
  endtask
  task automatic t_icon;
    wr(8'h82, 8'hc0);
    wr(8'h90, 8'h12);
    wr(8'h91, 8'hfd);
    wr(8'h92, 8'hab);
    wr(8'h93, 8'h03);
    idle();
    chk({icon_on_out, icon_double_out, icon_size_out}, 9'h1ff);
    chk(icon_x_out, 11'h512);
    chk(icon_y_out, 11'h3ab);
    wr(8'h82, 8'h80);
    idle();
    chk({icon_on_out, icon_double_out, icon_size_out}, 9'h13f);
  endtask
  task automatic t_cursor;
    wr(8'h88, 8'hf3);
    wr(8'h89, 8'h06);
    wr(8'h8a, 8'h7d);
    wr(8'h8b, 8'h05);
    idle();
    chk(cursor_x_out, 11'h6f3);
    chk(cursor_y_out, 11'h57d);
    chk({x_clip, y_clip, x_skip, y_skip}, 0);
    wr(8'h89, 8'h0e);
    wr(8'h8b, 8'h0d);
    idle();
    chk({x_clip, y_clip, cursor_x_out, cursor_y_out}, 24'hc0_0000);
    chk(x_skip, 5'h13);
    chk(y_skip, 5'h1d);
  endtask
  task automatic t_colour;
    logic [7:0] cv [6] = '{8'h00, 8'hff, 8'he0, 8'h1c, 8'h03, 8'ha5};
    for (int i = 0; i < 6; i++) begin
      wr(8'h8c, cv[i]);
      wr(8'h8d, ~cv[i]);
      idle();
      chk(fore_q, ex(cv[i]));
      chk(back_q, ex(~cv[i]));
    end
  endtask
  initial begin
    t_reset();
    t_scratch();
    t_reserved();
    t_pattern();
    t_icon();
    t_cursor();
    t_colour();
    t_reset();
    end_of_test();
  end
  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (2000) @(negedge clk_in);
    fails++;
    end_of_test();
  end
endmodule // ico_overlay_regs_tb
`default_nettype wire
